// ==== rtl/fdc_pkg.sv ====
// Contract
// - basic velocity mode takes target speed at 6042h, reports measured speed at 6044h
// - basic velocity values scale by factor at 604Ch, reset value one; only the 6044h reading is scaled, the 6042h target passes unscaled
// - profile velocity target at 60FFh, actual at 606Ch, increments per second
// - increment resolution from 608Fh, default 65536 per revolution
// - torque target at 6071h, actual at 6077h, in thousandths of rated
// - command word written at 2101h or 6040h, decoded to internal form
// - bit0 high advances to ready; low ramp stops then ready-to-switch-on
// - bit1 low coasts, coast-stop-active, then switch-on-inhibited
// - bit2 low fast stops within set time, then switch-on-inhibited
// - bit3 high enables operation given run permit; low inhibits operation
// - with fieldbus run-permit source, bit3 itself asserts run permit
// - bit4 low forces ramp output to zero; high enables it
// - bit5 low freezes ramp output; high resumes ramping
// - bit6 low forces ramp input to zero; high proceeds to operating
// - rising edge of bit7 clears fault, enters switch-on-inhibited
// - bit8 requests first jog speed, bit9 second jog speed
// - bits 6 to 9 act only when fieldbus is their selected source
// - bit10 low with nonzero word or reference retains last values; the code still stores such a word when the stored word has bit10 high
// - bit11 selects secondary location when fieldbus is location source
// - bits 12 to 15 stored as application bits
package fdc_pkg;
    // ------------------------------------------------------------
    // object indices
    // ------------------------------------------------------------
    localparam logic [15:0] OBJ_CMD_VENDOR   = 16'h2101;
    localparam logic [15:0] OBJ_CMD_STD      = 16'h6040;
    localparam logic [15:0] OBJ_VL_TARGET    = 16'h6042;
    localparam logic [15:0] OBJ_VL_ACTUAL    = 16'h6044;
    localparam logic [15:0] OBJ_VL_FACTOR    = 16'h604c;
    localparam logic [15:0] OBJ_PV_TARGET    = 16'h60ff;
    localparam logic [15:0] OBJ_PV_ACTUAL    = 16'h606c;
    localparam logic [15:0] OBJ_RESOLUTION   = 16'h608f;
    localparam logic [15:0] OBJ_TQ_TARGET    = 16'h6071;
    localparam logic [15:0] OBJ_TQ_ACTUAL    = 16'h6077;
    // ------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------
    localparam int B_RAMP_STOP  = 0;
    localparam int B_COAST_STOP = 1;
    localparam int B_FAST_STOP  = 2;
    localparam int B_ENABLE_OP  = 3;
    localparam int B_RAMP_OUT   = 4;
    localparam int B_RAMP_HOLD  = 5;
    localparam int B_RAMP_IN    = 6;
    localparam int B_RESET      = 7;
    localparam int B_JOG1       = 8;
    localparam int B_JOG2       = 9;
    localparam int B_REMOTE     = 10;
    localparam int B_LOCATION   = 11;
    localparam int B_APP_LO     = 12;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] RST_VL_FACTOR   = 32'h0000_0001;
    localparam logic [31:0] RST_RESOLUTION  = 32'h0001_0000;
    localparam logic [15:0] RST_CMD         = 16'h0000;
    localparam int          CLK_HZ          = 40_000_000;
    localparam int          FAST_STOP_US    = 1000;
    localparam int          FAST_STOP_CYC   = (FAST_STOP_US * (CLK_HZ / 1_000_000));
    // ------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_VL  = 3'b000,
        MODE_PV  = 3'b001,
        MODE_CSV = 3'b010,
        MODE_PT  = 3'b011,
        MODE_CST = 3'b100
    } fdc_mode_t;
    typedef enum logic [3:0] {
        ST_INHIBITED   = 4'b0000,
        ST_READY_SWON  = 4'b0001,
        ST_READY_OP    = 4'b0010,
        ST_OP_ENABLED  = 4'b0011,
        ST_RAMP_STOP   = 4'b0100,
        ST_COAST_STOP  = 4'b0101,
        ST_FAST_STOP   = 4'b0110,
        ST_FAULT       = 4'b0111
    } fdc_state_t;
endpackage

// ==== rtl/fdc_cmd_if.sv ====
`timescale 1ns/1ps
interface fdc_cmd_if;
    logic [15:0] word;
    logic        ramp_stop_ctrl;
    logic        coast_stop_ctrl;
    logic        fast_stop_ctrl;
    logic        enable_op;
    logic        reset_edge;
    modport src (output word, ramp_stop_ctrl, coast_stop_ctrl, fast_stop_ctrl, enable_op,
                 reset_edge);
    modport dst (input word, ramp_stop_ctrl, coast_stop_ctrl, fast_stop_ctrl, enable_op,
                 reset_edge);
endinterface

// ==== rtl/fdc_state_machine.sv ====
`timescale 1ns/1ps
module fdc_state_machine
    import fdc_pkg::*;
#(
    parameter int FAST_CYC = FAST_STOP_CYC
)(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // decoded command
    fdc_cmd_if.dst          cmd,
    input  wire logic       run_permit,
    input  wire logic       fault_in,
    input  wire logic       speed_zero,
    // state
    output fdc_state_t      state,
    output logic            running
);
    fdc_state_t  state_ff, nxt_state;
    logic [31:0] tmr_ff, nxt_tmr;

    // ------------------------------------------------------------
    // drive state machine
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_tmr   = '0;
        case (state_ff)
            ST_FAULT:
            begin
                if (cmd.reset_edge)
                    nxt_state = ST_INHIBITED;
            end
            ST_COAST_STOP:
            begin
                if (speed_zero)
                    nxt_state = ST_INHIBITED;
            end
            ST_FAST_STOP:
            begin
                nxt_tmr = tmr_ff + 32'h1;
                // the time limit bounds the stop even if speed never reports zero
                if (speed_zero || tmr_ff >= 32'(FAST_CYC - 1))
                    nxt_state = ST_INHIBITED;
            end
            default:
            begin
                if (fault_in)
                    nxt_state = ST_FAULT;
                else if (!cmd.coast_stop_ctrl)
                    nxt_state = (state_ff == ST_INHIBITED) ? ST_INHIBITED : ST_COAST_STOP;
                else if (!cmd.fast_stop_ctrl)
                    nxt_state = (state_ff == ST_INHIBITED) ? ST_INHIBITED : ST_FAST_STOP;
                else if (!cmd.ramp_stop_ctrl)
                begin
                    if (state_ff == ST_OP_ENABLED || state_ff == ST_READY_OP)
                        nxt_state = ST_RAMP_STOP;
                    else if (state_ff == ST_RAMP_STOP && speed_zero)
                        nxt_state = ST_READY_SWON;
                    else if (state_ff == ST_INHIBITED)
                        nxt_state = ST_READY_SWON;
                end
                else if (state_ff == ST_READY_SWON || state_ff == ST_RAMP_STOP)
                    nxt_state = ST_READY_OP;
                else if (state_ff == ST_READY_OP && cmd.enable_op && run_permit)
                    nxt_state = ST_OP_ENABLED;
                else if (state_ff == ST_OP_ENABLED && !(cmd.enable_op && run_permit))
                    nxt_state = ST_READY_OP;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_INHIBITED;
            tmr_ff   <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            tmr_ff   <= nxt_tmr;
        end
    end

    assign state   = state_ff;
    assign running = (state_ff == ST_OP_ENABLED);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_COAST_WINS: assert property (@(posedge clock) disable iff (!rst_n)
        (!fault_in && !cmd.coast_stop_ctrl && state_ff inside {ST_OP_ENABLED, ST_READY_OP})
        |=> state_ff == ST_COAST_STOP)
        else $error("coast stop not taken");
    AST_FAST_BOUND: assert property (@(posedge clock) disable iff (!rst_n)
        (state_ff == ST_FAST_STOP && tmr_ff == 32'(FAST_CYC - 1)) |=> state_ff != ST_FAST_STOP)
        else $error("fast stop exceeded time");
    AST_FAULT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        (state_ff == ST_FAULT && !cmd.reset_edge) |=> state_ff == ST_FAULT)
        else $error("fault left without reset edge");
    AST_FAULT_CLR: assert property (@(posedge clock) disable iff (!rst_n)
        (state_ff == ST_FAULT && cmd.reset_edge) |=> state_ff == ST_INHIBITED)
        else $error("fault reset ignored");
    AST_PERMIT: assert property (@(posedge clock) disable iff (!rst_n)
        (state_ff == ST_OP_ENABLED) |-> $past(cmd.enable_op && run_permit))
        else $error("enabled without permit");
    COV_RUN: cover property (@(posedge clock) disable iff (!rst_n) state_ff == ST_OP_ENABLED);
    COV_FAST: cover property (@(posedge clock) disable iff (!rst_n) state_ff == ST_FAST_STOP);
    COV_RESET: cover property (@(posedge clock) disable iff (!rst_n)
        state_ff == ST_FAULT ##1 state_ff == ST_INHIBITED);
endmodule // fdc_state_machine

// ==== rtl/fdc_decoder.sv ====
`timescale 1ns/1ps
module fdc_decoder
    import fdc_pkg::*;
#(
    parameter int FAST_CYC = FAST_STOP_CYC
)(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // object write port
    input  wire logic        obj_wr,
    input  wire logic [15:0] obj_index,
    input  wire logic [31:0] obj_wdata,
    // object read port
    input  wire logic        obj_rd,
    output logic [31:0]      obj_rdata,
    output logic             obj_rvalid,
    output logic             obj_err,
    // drive side
    input  wire logic [31:0] actual_speed_rpm,
    input  wire logic [31:0] actual_torque,
    input  wire logic        fault_in,
    input  wire logic        speed_zero,
    input  wire logic [2:0]  op_mode,
    // source selection
    input  wire logic        permit_from_bus,
    input  wire logic        ramp_in_from_bus,
    input  wire logic        reset_from_bus,
    input  wire logic        jog_from_bus,
    input  wire logic        loc_from_bus,
    input  wire logic        run_permit_ext,
    // decoded outputs
    output fdc_state_t       drive_state,
    output logic             running,
    output logic             ramp_stop_active,
    output logic             coast_stop_active,
    output logic             fast_stop_active,
    output logic             ramp_out_zero,
    output logic             ramp_hold,
    output logic             ramp_in_zero,
    output logic             jog1_req,
    output logic             jog2_req,
    output logic             bus_control,
    output logic             ref_locked,
    output logic             location_select,
    output logic [3:0]       app_bits,
    output logic [31:0]      target_value,
    output logic             target_strobe
);
    logic [15:0] word_ff, nxt_word;
    logic [31:0] ref_ff, nxt_ref;
    logic [31:0] fac_ff, nxt_fac;
    logic [31:0] res_ff, nxt_res;
    logic        rst_bit_ff, nxt_rst_bit;
    logic        strobe_ff, nxt_strobe;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        rv_ff, nxt_rv;
    logic        err_ff, nxt_err;
    logic        wr_cmd, wr_ref, permit;
    fdc_mode_t   mode;

    fdc_cmd_if cmd_bus ();

    assign mode = fdc_mode_t'(op_mode);

    // ------------------------------------------------------------
    // object writes
    // ------------------------------------------------------------
    assign wr_cmd = obj_wr && (obj_index == OBJ_CMD_VENDOR || obj_index == OBJ_CMD_STD);
    always_comb
    begin
        wr_ref = 1'b0;
        if (obj_wr)
        begin
            case (mode)
                MODE_VL:  wr_ref = (obj_index == OBJ_VL_TARGET);
                MODE_PV,
                MODE_CSV: wr_ref = (obj_index == OBJ_PV_TARGET);
                MODE_PT,
                MODE_CST: wr_ref = (obj_index == OBJ_TQ_TARGET);
                default:  wr_ref = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        nxt_word    = word_ff;
        nxt_ref     = ref_ff;
        nxt_fac     = fac_ff;
        nxt_res     = res_ff;
        nxt_strobe  = 1'b0;
        nxt_rst_bit = word_ff[B_RESET];
        // a word with bit 10 low while it or the reference is nonzero is dropped if the stored word has bit 10 low
        if (wr_cmd && (obj_wdata[B_REMOTE] || (obj_wdata[15:0] == 16'h0000 && ref_ff == '0)))
            nxt_word = obj_wdata[15:0];
        else if (wr_cmd && word_ff[B_REMOTE])
            nxt_word = obj_wdata[15:0];
        // periodic targets in cyclic modes are taken whenever they arrive while the stored word has bit 10 high
        // with bit 10 low the last reference is kept, whatever the word holds
        if (wr_ref && !ref_locked)
        begin
            nxt_ref    = obj_wdata;
            nxt_strobe = 1'b1;
        end
        if (obj_wr && obj_index == OBJ_VL_FACTOR)
            nxt_fac = obj_wdata;
        if (obj_wr && obj_index == OBJ_RESOLUTION)
            nxt_res = obj_wdata;
    end

    // ------------------------------------------------------------
    // object reads
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_rv    = obj_rd;
        nxt_err   = 1'b0;
        nxt_rdata = 32'h0000_0000;
        if (obj_rd)
        begin
            case (obj_index)
                OBJ_VL_ACTUAL:  nxt_rdata = 32'(actual_speed_rpm * fac_ff);
                OBJ_PV_ACTUAL:  nxt_rdata = 32'((64'(actual_speed_rpm) * 64'(res_ff))
                                                / 64'd60);
                OBJ_TQ_ACTUAL:  nxt_rdata = actual_torque;
                OBJ_VL_FACTOR:  nxt_rdata = fac_ff;
                OBJ_RESOLUTION: nxt_rdata = res_ff;
                default:        nxt_err   = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_ff    <= RST_CMD;
            ref_ff     <= '0;
            fac_ff     <= RST_VL_FACTOR;
            res_ff     <= RST_RESOLUTION;
            rst_bit_ff <= 1'b0;
            strobe_ff  <= 1'b0;
            rdata_ff   <= '0;
            rv_ff      <= 1'b0;
            err_ff     <= 1'b0;
        end
        else
        begin
            word_ff    <= nxt_word;
            ref_ff     <= nxt_ref;
            fac_ff     <= nxt_fac;
            res_ff     <= nxt_res;
            rst_bit_ff <= nxt_rst_bit;
            strobe_ff  <= nxt_strobe;
            rdata_ff   <= nxt_rdata;
            rv_ff      <= nxt_rv;
            err_ff     <= nxt_err;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign cmd_bus.word            = word_ff;
    assign cmd_bus.ramp_stop_ctrl  = word_ff[B_RAMP_STOP];
    assign cmd_bus.coast_stop_ctrl = word_ff[B_COAST_STOP];
    assign cmd_bus.fast_stop_ctrl  = word_ff[B_FAST_STOP];
    assign cmd_bus.enable_op       = word_ff[B_ENABLE_OP];
    assign cmd_bus.reset_edge      = reset_from_bus && word_ff[B_RESET] && !rst_bit_ff;
    assign permit = permit_from_bus ? word_ff[B_ENABLE_OP] : run_permit_ext;

    fdc_state_machine #(
        .FAST_CYC (FAST_CYC)
    ) u_sm (
        .clock      (clock),
        .rst_n      (rst_n),
        .cmd        (cmd_bus),
        .run_permit (permit),
        .fault_in   (fault_in),
        .speed_zero (speed_zero),
        .state      (drive_state),
        .running    (running)
    );

    assign ramp_stop_active  = (drive_state == ST_RAMP_STOP);
    assign coast_stop_active = (drive_state == ST_COAST_STOP);
    assign fast_stop_active  = (drive_state == ST_FAST_STOP);
    assign ramp_out_zero     = !word_ff[B_RAMP_OUT];
    assign ramp_hold         = !word_ff[B_RAMP_HOLD];
    assign ramp_in_zero      = ramp_in_from_bus && !word_ff[B_RAMP_IN];
    assign jog1_req          = jog_from_bus && word_ff[B_JOG1];
    assign jog2_req          = jog_from_bus && word_ff[B_JOG2];
    assign bus_control       = word_ff[B_REMOTE] || (word_ff == '0 && ref_ff == '0);
    assign ref_locked        = !word_ff[B_REMOTE];
    assign location_select   = loc_from_bus && word_ff[B_LOCATION];
    assign app_bits          = word_ff[15:B_APP_LO];
    assign target_value      = ref_ff;
    assign target_strobe     = strobe_ff;
    assign obj_rdata         = rdata_ff;
    assign obj_rvalid        = rv_ff;
    assign obj_err           = err_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_CMD_TAKE: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_cmd && obj_wdata[B_REMOTE]) |=> word_ff == $past(obj_wdata[15:0]))
        else $error("command word not stored");
    AST_RETAIN: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_cmd && !obj_wdata[B_REMOTE] && !word_ff[B_REMOTE]
         && (obj_wdata[15:0] != 16'h0000 || ref_ff != '0))
        |=> $stable(word_ff))
        else $error("word not retained");
    AST_FAC_RST: assert property (@(posedge clock) disable iff (!rst_n)
        (obj_rd && obj_index == OBJ_VL_FACTOR && !(obj_wr && obj_index == OBJ_VL_FACTOR)
         && ($past(!rst_n) || $past(!rst_n, 2))) |=> obj_rdata == RST_VL_FACTOR)
        else $error("factor reset value wrong");
    AST_RD_LAT: assert property (@(posedge clock) disable iff (!rst_n)
        (obj_rd && obj_index == OBJ_TQ_ACTUAL) |=> obj_rvalid && obj_rdata == $past(actual_torque))
        else $error("torque readback wrong");
    COV_LOC: cover property (@(posedge clock) disable iff (!rst_n) location_select);
endmodule // fdc_decoder

// ==== sim/fdc_master_model.sv ====
`timescale 1ns/1ps
module fdc_master_model
(
    // clock
    clock,
    // object requests
    obj_wr,
    obj_rd,
    obj_index,
    obj_wdata,
    // answers
    obj_rdata,
    obj_rvalid,
    obj_err
);
    input  wire logic        clock;
    output logic             obj_wr = 1'b0;
    output logic             obj_rd = 1'b0;
    output logic [15:0]      obj_index = 16'h0000;
    output logic [31:0]      obj_wdata = 32'h0000_0000;
    input  wire logic [31:0] obj_rdata;
    input  wire logic        obj_rvalid;
    input  wire logic        obj_err;
    // a released bus shows the inverse of its last value, never a stale copy
    task automatic wr(input logic [15:0] idx, input logic [31:0] data);
        @(posedge clock);
        obj_wr    <= 1'b1;
        obj_index <= idx;
        obj_wdata <= data;
        @(posedge clock);
        obj_wr    <= 1'b0;
        obj_index <= ~idx;
        obj_wdata <= ~data;
    endtask
    task automatic rd(input logic [15:0] idx, output logic [31:0] data, output logic err);
        int n;
        @(posedge clock);
        obj_rd    <= 1'b1;
        obj_index <= idx;
        @(posedge clock);
        obj_rd    <= 1'b0;
        obj_index <= ~idx;
        for (n = 0; n < 4; n++)
        begin
            @(negedge clock);
            if (obj_rvalid === 1'b1 || obj_err === 1'b1)
                break;
        end
        data = (n < 4) ? obj_rdata : 'x;
        err  = obj_err;
    endtask
    // trajectory lives here: one fresh target per fixed period
    task automatic cyclic(input logic [15:0] idx, input logic [31:0] v, input int n, input int p);
        for (int i = 0; i < n; i++)
        begin
            wr(idx, v + 32'(i));
            repeat (p) @(posedge clock);
        end
    endtask
endmodule // fdc_master_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench
    import fdc_pkg::*;
    ;
    localparam int FAST = 8;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        obj_wr, obj_rd, obj_rvalid, obj_err, rerr;
    logic [15:0] obj_index;
    logic [31:0] obj_wdata, obj_rdata, target_value, rdata;
    logic [31:0] actual_speed_rpm = 32'h0000_0064;
    logic [31:0] actual_torque = 32'h0000_000a;
    logic        fault_in = 1'b0, speed_zero = 1'b0, run_permit_ext = 1'b0;
    logic [2:0]  op_mode = 3'h0;
    logic        permit_from_bus = 1'b1, ramp_in_from_bus = 1'b1, reset_from_bus = 1'b1;
    logic        jog_from_bus = 1'b1, loc_from_bus = 1'b1;
    fdc_state_t  drive_state;
    logic        running, ramp_stop_active, coast_stop_active, fast_stop_active;
    logic        ramp_out_zero, ramp_hold, ramp_in_zero, jog1_req, jog2_req;
    logic        bus_control, ref_locked, location_select, target_strobe;
    logic [3:0]  app_bits;
    logic [15:0] tidx [5] = '{16'h6042, 16'h60ff, 16'h60ff, 16'h6071, 16'h6071};
    int          bad_count = 0, num_checks = 0, strobe_cnt = 0;
    fdc_decoder #(.FAST_CYC(FAST)) dut (.clock, .rst_n, .obj_wr, .obj_index, .obj_wdata,
        .obj_rd, .obj_rdata, .obj_rvalid, .obj_err, .actual_speed_rpm, .actual_torque,
        .fault_in, .speed_zero, .op_mode, .permit_from_bus, .ramp_in_from_bus,
        .reset_from_bus, .jog_from_bus, .loc_from_bus, .run_permit_ext, .drive_state,
        .running, .ramp_stop_active, .coast_stop_active, .fast_stop_active, .ramp_out_zero,
        .ramp_hold, .ramp_in_zero, .jog1_req, .jog2_req, .bus_control, .ref_locked,
        .location_select, .app_bits, .target_value, .target_strobe);
    fdc_master_model master (.clock, .obj_wr, .obj_rd, .obj_index, .obj_wdata,
        .obj_rdata, .obj_rvalid, .obj_err);
    always #12.5 clock = ~clock;
    always @(posedge clock)
        if (target_strobe === 1'b1)
            strobe_cnt <= strobe_cnt + 1;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic cmd(input logic [15:0] w);
        master.wr(16'h2101, {16'h0000, w});
        cyc(3);
    endtask
    task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
        master.rd(idx, rdata, rerr);
        chk("read data", rdata, exp);
        chk("read error", {31'h0, rerr}, 32'h0);
    endtask
    task automatic st(input fdc_state_t s, input logic [2:0] stops);
        chk("state", {24'h0, drive_state, ramp_stop_active, coast_stop_active,
            fast_stop_active, running}, {24'h0, s, stops, s == ST_OP_ENABLED});
    endtask
    task automatic dec(input logic [7:0] f, input logic [3:0] a);
        chk("flags", {24'h0, ramp_out_zero, ramp_hold, ramp_in_zero, jog1_req, jog2_req,
            bus_control, location_select, 1'b0}, {24'h0, f});
        chk("app bits", {28'h0, app_bits}, {28'h0, a});
    endtask
    task automatic go_op;
        cmd(16'h0406);
        cmd(16'h0407);
        cmd(16'h040f);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // whole run needs a few hundred cycles
    initial
    begin
        #(25 * 20000);
        bad_count++;
        results;
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        rchk(16'h604c, 32'h0000_0001);
        rchk(16'h608f, 32'h0001_0000);
        rchk(16'h6044, 32'h0000_0064);
        rchk(16'h606c, 32'h0001_aaaa);
        rchk(16'h6077, 32'h0000_000a);
        master.rd(16'h1234, rdata, rerr);
        chk("unmapped", {31'h0, rerr}, 32'h1);
        $display("test reads done");
        cmd(16'h047f);
        dec(8'h04, 4'h0);
        cmd(16'h0407);
        dec(8'he4, 4'h0);
        master.wr(16'h6040, 32'h0000_ff7f);
        cyc(3);
        dec(8'h1e, 4'hf);
        @(posedge clock) {jog_from_bus, loc_from_bus, ramp_in_from_bus} <= 3'h0;
        cmd(16'hff07);
        dec(8'hc4, 4'hf);
        @(posedge clock) {jog_from_bus, loc_from_bus, ramp_in_from_bus, permit_from_bus} <= 4'he;
        $display("test decode done");
        cmd(16'h0406);
        st(ST_READY_SWON, 3'h0);
        cmd(16'h0407);
        st(ST_READY_OP, 3'h0);
        cmd(16'h040f);
        st(ST_READY_OP, 3'h0);
        @(posedge clock) permit_from_bus <= 1'b1;
        cmd(16'h040f);
        st(ST_OP_ENABLED, 3'h0);
        cmd(16'h0407);
        st(ST_READY_OP, 3'h0);
        cmd(16'h040f);
        cmd(16'h0408);
        st(ST_COAST_STOP, 3'h2);
        @(posedge clock) speed_zero <= 1'b1;
        cyc(3);
        st(ST_INHIBITED, 3'h0);
        @(posedge clock) speed_zero <= 1'b0;
        go_op;
        cmd(16'h040a);
        st(ST_FAST_STOP, 3'h1);
        cyc(FAST + 2);
        st(ST_INHIBITED, 3'h0);
        go_op;
        cmd(16'h040e);
        st(ST_RAMP_STOP, 3'h4);
        @(posedge clock) speed_zero <= 1'b1;
        cyc(3);
        st(ST_READY_SWON, 3'h0);
        $display("test states done");
        @(posedge clock) fault_in <= 1'b1;
        cyc(3);
        st(ST_FAULT, 3'h0);
        @(posedge clock) {fault_in, reset_from_bus} <= 2'h0;
        cmd(16'h0486);
        st(ST_FAULT, 3'h0);
        @(posedge clock) reset_from_bus <= 1'b1;
        cmd(16'h0487);
        st(ST_FAULT, 3'h0);
        cmd(16'h0407);
        cmd(16'h0487);
        st(ST_INHIBITED, 3'h0);
        cmd(16'h0007);
        cmd(16'h3007);
        chk("retained app", {28'h0, app_bits}, 32'h0);
        chk("lock", {30'h0, bus_control, ref_locked}, 32'h1);
        master.wr(16'h6042, 32'h0000_0055);
        cyc(3);
        chk("held ref", target_value, 32'h0);
        cmd(16'h0000);
        chk("zero lock", {30'h0, bus_control, ref_locked}, 32'h3);
        cmd(16'h5406);
        chk("app bits", {28'h0, app_bits}, 32'h5);
        $display("test fault and retain done");
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clock) op_mode <= 3'(i);
            master.wr(tidx[i], 32'h0000_0100 + 32'(i));
            cyc(3);
            chk("target", target_value, 32'h0000_0100 + 32'(i));
            chk("strobes", 32'(strobe_cnt), 32'(i + 1));
        end
        @(posedge clock) op_mode <= 3'h3;
        master.wr(16'h60ff, 32'h0000_0999);
        cyc(3);
        chk("wrong object", target_value, 32'h0000_0104);
        @(posedge clock) op_mode <= 3'h2;
        master.cyclic(16'h60ff, 32'h0000_0200, 4, 6);
        cyc(3);
        chk("cyclic speed", target_value, 32'h0000_0203);
        @(posedge clock) op_mode <= 3'h4;
        master.cyclic(16'h6071, 32'h0000_0300, 3, 6);
        cyc(3);
        chk("cyclic torque", target_value, 32'h0000_0302);
        chk("strobes", 32'(strobe_cnt), 32'h0000_000c);
        $display("test targets done");
        results;
    end
endmodule // testbench
